// *** drn_pkg.sv ***
package drn_pkg;

  // Register indices on the plain register port.
  localparam logic [3:0] ADDR_CTRL      = 4'h0;  // Channel control bits.
  localparam logic [3:0] ADDR_MEM       = 4'h1;  // Memory address (repeat).
  localparam logic [3:0] ADDR_PERI      = 4'h2;  // Peripheral low address.
  localparam logic [3:0] ADDR_RCOUNT    = 4'h3;  // Hold byte [15:8], live byte [7:0].
  localparam logic [3:0] ADDR_SRC_A     = 4'h4;  // Source address, channel A.
  localparam logic [3:0] ADDR_DST_B     = 4'h5;  // Destination address, channel B.
  localparam logic [3:0] ADDR_FCOUNT    = 4'h6;  // Full transfer count.
  localparam logic [3:0] ADDR_STATUS    = 4'h7;  // Block state, read only.

  // Control register bit positions.
  localparam int BIT_TRANSFER_EN  = 0;
  localparam int BIT_REPEAT_EN    = 1;
  localparam int BIT_END_IRQ_EN   = 2;
  localparam int BIT_DIRECTION    = 3;
  localparam int BIT_SIZE         = 4;
  localparam int BIT_INC_DEC      = 5;
  localparam int BIT_FULL_ADDR    = 6;
  localparam int BIT_BLOCK_EN     = 7;
  localparam int BIT_AUTO_REQ     = 8;
  localparam int BIT_BURST        = 9;
  localparam int BIT_SRC_STEP     = 10;  // Source steps when set.
  localparam int BIT_SRC_DEC      = 11;
  localparam int BIT_DST_STEP     = 12;  // Destination steps when set.
  localparam int BIT_DST_DEC      = 13;
  localparam int BIT_TRIG_LO      = 16;  // Repeat trigger enables, 6 bits.
  localparam int CTRL_WIDTH       = 22;

  // Reset values.
  localparam logic [21:0] CTRL_RESET  = 22'h000000;
  localparam logic [23:0] ADDR_RESET  = 24'h000000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // Upper byte of every peripheral-side address.
  localparam logic [7:0]  PERI_HIGH   = 8'hFF;

  // Number of repeat trigger sources: converter end, serial tx, serial rx, timers 0..2.
  localparam int N_TRIG = 6;

  // Channel sequencer states.
  typedef enum logic [1:0] {
    DRN_IDLE,
    DRN_READ,
    DRN_WRITE
  } drn_state_type;

endpackage

// *** drn_dma.sv ***
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

// Repeat and normal transfer control of one DMA channel. A move is
// split into a read half and a write half on the system bus, and each
// half waits for the grant. Repeat mode walks a memory pointer against
// a fixed peripheral address and rewinds it after each round. Normal
// mode pairs a source and a destination pointer with a 16-bit count.
module drn_dma (
  input  wire logic        clk,           // System clock, 10 MHz.
  input  wire logic        rst_b,         // Synchronous reset, active low.
  input  wire logic [3:0]  reg_addr,      // Register index.
  input  wire logic [31:0] reg_wdata,     // Write data.
  input  wire logic        reg_wr,        // Write strobe.
  input  wire logic        reg_rd,        // Read strobe.
  output logic      [31:0] reg_rdata,     // Read data, valid the cycle after the strobe.
  input  wire logic [5:0]  trig_in,       // Internal activation pulses.
  input  wire logic        ext_req_b,     // External request, active low.
  input  wire logic        bus_grant,     // Bus granted to this channel.
  output logic             bus_req,       // Bus request.
  output logic [23:0]      bus_addr,      // Bus address.
  output logic             bus_rd,        // Read cycle strobe.
  output logic             bus_wr,        // Write cycle strobe.
  output logic             bus_word,      // Word-sized access.
  output logic [15:0]      bus_wdata,     // Data written.
  input  wire logic [15:0] bus_rdata,     // Data read.
  output logic             end_irq        // Transfer-end interrupt request.
);

  // Control and address registers.
  // Software should stop the channel before rewriting its pointers.
  logic [21:0] ctrl_reg;             // Channel control bits.
  logic [23:0] mem_addr_reg;         // Memory address.
  logic [15:0] peri_addr_reg;        // Peripheral low address.
  logic [7:0]  count_hold_reg;       // Repeat count hold byte.
  logic [7:0]  count_live_reg;       // Repeat counting byte.
  logic [23:0] src_addr_reg;         // Normal-mode source.
  logic [23:0] dst_addr_reg;         // Normal-mode destination.
  logic [15:0] full_count_reg;       // Normal-mode count.
  logic [15:0] data_reg;             // Data held between read and write.
  logic        pending_reg;          // Latched transfer request.
  drn_pkg::drn_state_type state_reg; // Sequencer state.

  // Decoded mode bits and move terms. The mode bits are plain wires from the control register,
  // so a control write takes effect at the very next clock edge.
  logic        enable;               // Channel may move data.
  logic        repeat_mode;          // Repeat operation selected.
  logic        normal_mode;          // Paired full-address operation.
  logic        word_size;            // Moves are 16 bits wide.
  logic [23:0] step;                 // Address stride of one move.
  logic        request;              // A move is asked for this cycle.
  logic        done_move;            // Write half of a move accepted.
  logic        start_move;           // Sequencer leaves idle at this edge when it is in idle.

  // Returns the next address for a stepping pointer.
  // The sum wraps at 24 bits on purpose, so a pointer that runs past
  // either end of the address space comes round to the other end.
  function automatic logic [23:0] step_addr(input logic [23:0] a,
                                            input logic        dec,
                                            input logic [23:0] s);
    step_addr = dec ? a - s : a + s;
  endfunction

  assign enable      = ctrl_reg[drn_pkg::BIT_TRANSFER_EN];
  // The repeat channel runs only with its irq enable clear.
  // Full addressing must be off too, so the two modes never overlap.
  assign repeat_mode = ctrl_reg[drn_pkg::BIT_REPEAT_EN] &
                       ~ctrl_reg[drn_pkg::BIT_END_IRQ_EN] &
                       ~ctrl_reg[drn_pkg::BIT_FULL_ADDR];
  // Channels A and B combine when full addressing is on without block mode.
  assign normal_mode = ctrl_reg[drn_pkg::BIT_FULL_ADDR] &
                       ~ctrl_reg[drn_pkg::BIT_BLOCK_EN];
  assign word_size   = ctrl_reg[drn_pkg::BIT_SIZE];
  // Byte moves step by one, word moves by two.
  // The same bit sets the size of each bus access.
  assign step        = word_size ? 24'h000002 : 24'h000001;

  // Only the sources of the active mode can ask for a move.
  // Masked triggers, and the external pin in repeat mode, are ignored
  // here, so they can never leave a stale pending flag behind.
  // Auto-request keeps the request high for the whole run.
  // Request source depends on mode; a low external input asks in normal mode.
  always_comb begin
    request = 1'b0;
    if (repeat_mode) begin
      request = |(trig_in & ctrl_reg[drn_pkg::BIT_TRIG_LO +: drn_pkg::N_TRIG]);
    end else if (normal_mode) begin
      request = ctrl_reg[drn_pkg::BIT_AUTO_REQ] | ~ext_req_b;
    end
  end

  // The sequencer starts a move when a latched request meets a mode.
  assign start_move = enable && pending_reg && (repeat_mode || normal_mode);

  // A move completes when the write cycle is granted.
  assign done_move = (state_reg == drn_pkg::DRN_WRITE) && bus_grant;

  // Latch requests so a pulse arriving mid-move is kept; the move consumes it.
  // A set has priority over the consume, so a pulse that lands as a
  // move starts is kept for the following move.
  // Clearing the enable drops a waiting request, so a re-enable does
  // not replay a trigger that came while the channel was stopped.
  // Only one request is remembered; extra pulses merge into it.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pending_reg <= 1'b0;
    end else if (request && enable) begin
      pending_reg <= 1'b1;
    end else if (state_reg == drn_pkg::DRN_IDLE && pending_reg) begin
      pending_reg <= 1'b0;
    end else if (!enable) begin
      pending_reg <= 1'b0;
    end
  end

  // Sequencer: one read, one write per request.
  // Each half waits in its state until the bus grants it, so wait
  // states of any length stretch the move without losing it.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg <= drn_pkg::DRN_IDLE;
    end else begin
      case (state_reg)
        drn_pkg::DRN_IDLE: begin
          if (enable && (repeat_mode || normal_mode) && pending_reg) begin
            state_reg <= drn_pkg::DRN_READ;
          end
        end
        drn_pkg::DRN_READ: begin
          if (bus_grant) begin
            state_reg <= drn_pkg::DRN_WRITE;
          end
        end
        drn_pkg::DRN_WRITE: begin
          if (bus_grant) begin
            state_reg <= drn_pkg::DRN_IDLE;
          end
        end
        default: begin
          // Unused encodings fall back to idle.
          state_reg <= drn_pkg::DRN_IDLE;
        end
      endcase
    end
  end

  // Bus outputs, registered from the next state.
  // Strobes and address stand unchanged until the far side grants the
  // cycle, which lets a slow memory stretch a move.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bus_req   <= 1'b0;
      bus_addr  <= drn_pkg::ADDR_RESET;
      bus_rd    <= 1'b0;
      bus_wr    <= 1'b0;
      bus_word  <= 1'b0;
      bus_wdata <= 16'h0000;
    end else begin
      bus_rd <= 1'b0;
      bus_wr <= 1'b0;
      // Cycle steal drops the request between moves; burst with auto-request keeps it.
      // The request rises with the read strobe and falls after the write
      // is granted, unless a burst keeps it for the next move.
      bus_req <= (state_reg == drn_pkg::DRN_IDLE && start_move) ||
                 (state_reg == drn_pkg::DRN_READ) ||
                 (state_reg == drn_pkg::DRN_WRITE && !bus_grant) ||
                 (done_move && normal_mode && ctrl_reg[drn_pkg::BIT_BURST] &&
                  ctrl_reg[drn_pkg::BIT_AUTO_REQ] && full_count_reg != 16'h0001);
      bus_word <= word_size;
      if (state_reg == drn_pkg::DRN_IDLE && enable && pending_reg &&
          (repeat_mode || normal_mode)) begin
        bus_rd <= 1'b1;
        if (normal_mode) begin
          bus_addr <= src_addr_reg;
        end else if (ctrl_reg[drn_pkg::BIT_DIRECTION]) begin
          bus_addr <= {drn_pkg::PERI_HIGH, peri_addr_reg};
        end else begin
          bus_addr <= mem_addr_reg;
        end
      end else if (state_reg == drn_pkg::DRN_READ && bus_grant) begin
        bus_wr    <= 1'b1;
        bus_wdata <= bus_rdata;
        if (normal_mode) begin
          bus_addr <= dst_addr_reg;
        end else if (ctrl_reg[drn_pkg::BIT_DIRECTION]) begin
          bus_addr <= mem_addr_reg;
        end else begin
          bus_addr <= {drn_pkg::PERI_HIGH, peri_addr_reg};
        end
      end else if (state_reg != drn_pkg::DRN_IDLE && !bus_grant) begin
        bus_rd <= bus_rd;
        bus_wr <= bus_wr;
      end
    end
  end

  // Data captured from the read cycle.
  // The copy is kept for the status register as a debug aid.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      data_reg <= 16'h0000;
    end else if (state_reg == drn_pkg::DRN_READ && bus_grant) begin
      data_reg <= bus_rdata;
    end
  end

  // Control register; hardware clears the enable at normal-mode end.
  // A software write wins over that clear in the same cycle, so a fresh
  // start written at the last move is not lost. Repeat mode never
  // clears the enable by itself; only software stops it.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_reg <= drn_pkg::CTRL_RESET;
    end else if (reg_wr && reg_addr == drn_pkg::ADDR_CTRL) begin
      ctrl_reg <= reg_wdata[drn_pkg::CTRL_WIDTH-1:0];
    end else if (done_move && normal_mode && full_count_reg == 16'h0001) begin
      ctrl_reg[drn_pkg::BIT_TRANSFER_EN] <= 1'b0;
    end
  end

  // Repeat-mode memory address and counts; state is kept across disable.
  // Nothing here looks at the enable bit, so a re-enable resumes with
  // the next address and the remaining count.
  // The reload happens on the last move of a round, when the live byte
  // reads one; the address then rewinds by the span of the round.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mem_addr_reg   <= drn_pkg::ADDR_RESET;
      count_hold_reg <= drn_pkg::COUNT_RESET[7:0];
      count_live_reg <= drn_pkg::COUNT_RESET[7:0];
    end else if (reg_wr && reg_addr == drn_pkg::ADDR_MEM) begin
      mem_addr_reg <= reg_wdata[23:0];
    end else if (reg_wr && reg_addr == drn_pkg::ADDR_RCOUNT) begin
      count_hold_reg <= reg_wdata[15:8];
      count_live_reg <= reg_wdata[7:0];
    end else if (done_move && repeat_mode) begin
      if (count_live_reg == 8'h01) begin
        // Last move of the round: reload counter, rewind address.
        // A hold byte of zero stands for a round of 256 moves.
        count_live_reg <= count_hold_reg;
        mem_addr_reg <= step_addr(step_addr(mem_addr_reg,
                                            ctrl_reg[drn_pkg::BIT_INC_DEC], step),
                                  ~ctrl_reg[drn_pkg::BIT_INC_DEC],
                                  (count_hold_reg == 8'h00) ?
                                    (step << 8) :
                                    step * {16'h0000, count_hold_reg});
      end else begin
        // A zero live count wraps to 255, giving 256 moves in a round.
        count_live_reg <= count_live_reg - 8'h01;
        mem_addr_reg <= step_addr(mem_addr_reg,
                                  ctrl_reg[drn_pkg::BIT_INC_DEC], step);
      end
    end
  end

  // Peripheral low address, fixed during transfers.
  // Only software changes it; moves never step this pointer.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      peri_addr_reg <= drn_pkg::COUNT_RESET;
    end else if (reg_wr && reg_addr == drn_pkg::ADDR_PERI) begin
      peri_addr_reg <= reg_wdata[15:0];
    end
  end

  // Normal-mode pointers and count.
  // They update on the write grant of each move. A register write in
  // the same cycle wins, so software always sees its own value.
  // Each pointer has its own step and direction bits.
  // A zero count is legal and means the longest run.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      src_addr_reg   <= drn_pkg::ADDR_RESET;
      dst_addr_reg   <= drn_pkg::ADDR_RESET;
      full_count_reg <= drn_pkg::COUNT_RESET;
    end else begin
      if (reg_wr && reg_addr == drn_pkg::ADDR_SRC_A) begin
        src_addr_reg <= reg_wdata[23:0];
      end else if (done_move && normal_mode && ctrl_reg[drn_pkg::BIT_SRC_STEP]) begin
        src_addr_reg <= step_addr(src_addr_reg, ctrl_reg[drn_pkg::BIT_SRC_DEC], step);
      end
      if (reg_wr && reg_addr == drn_pkg::ADDR_DST_B) begin
        dst_addr_reg <= reg_wdata[23:0];
      end else if (done_move && normal_mode && ctrl_reg[drn_pkg::BIT_DST_STEP]) begin
        dst_addr_reg <= step_addr(dst_addr_reg, ctrl_reg[drn_pkg::BIT_DST_DEC], step);
      end
      if (reg_wr && reg_addr == drn_pkg::ADDR_FCOUNT) begin
        full_count_reg <= reg_wdata[15:0];
      end else if (done_move && normal_mode) begin
        // Zero wraps to FFFF so a zero start runs 65536 moves.
        full_count_reg <= full_count_reg - 16'h0001;
      end
    end
  end

  // End interrupt only from normal mode; repeat mode never raises it.
  // The request is a level. The end event wins over a clearing write
  // in the same cycle, so a completion is never lost.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      end_irq <= 1'b0;
    end else if (done_move && normal_mode && full_count_reg == 16'h0001 &&
                 ctrl_reg[drn_pkg::BIT_END_IRQ_EN]) begin
      end_irq <= 1'b1;
    end else if (reg_wr && reg_addr == drn_pkg::ADDR_CTRL &&
                 !reg_wdata[drn_pkg::BIT_END_IRQ_EN]) begin
      end_irq <= 1'b0;
    end
  end

  // Register read port, data one cycle after the strobe.
  // Data stand for exactly one cycle and are zero otherwise, so a
  // stale value is never taken for a fresh read.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      if (reg_addr == drn_pkg::ADDR_CTRL) begin
        reg_rdata <= {10'h000, ctrl_reg};
      end else if (reg_addr == drn_pkg::ADDR_MEM) begin
        reg_rdata <= {8'h00, mem_addr_reg};
      end else if (reg_addr == drn_pkg::ADDR_PERI) begin
        reg_rdata <= {16'h0000, peri_addr_reg};
      end else if (reg_addr == drn_pkg::ADDR_RCOUNT) begin
        reg_rdata <= {16'h0000, count_hold_reg, count_live_reg};
      end else if (reg_addr == drn_pkg::ADDR_SRC_A) begin
        reg_rdata <= {8'h00, src_addr_reg};
      end else if (reg_addr == drn_pkg::ADDR_DST_B) begin
        reg_rdata <= {8'h00, dst_addr_reg};
      end else if (reg_addr == drn_pkg::ADDR_FCOUNT) begin
        reg_rdata <= {16'h0000, full_count_reg};
      end else if (reg_addr == drn_pkg::ADDR_STATUS) begin
        reg_rdata <= {12'h000, data_reg, pending_reg, normal_mode, repeat_mode, 1'b0};
      end else begin
        reg_rdata <= 32'h00000000;
      end
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule

`default_nettype wire

// *** drn_dma_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
module drn_dma_chk (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [3:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        bus_grant,
  input wire logic        bus_req,
  input wire logic [23:0] bus_addr,
  input wire logic        bus_rd,
  input wire logic        bus_wr,
  input wire logic        bus_word,
  input wire logic [15:0] bus_wdata,
  input wire logic [15:0] bus_rdata,
  input wire logic        end_irq
);
  logic [21:0] ctl_q;  // Control bits as software last wrote them.
  logic [15:0] per_q;  // Peripheral low address as last written.
  logic        rep;    // Repeat mode is selected.
  logic        wg;     // A write cycle is accepted at this edge.
  // Shadows follow register writes so that bus cycles can be judged by mode.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctl_q <= 22'h000000;
      per_q <= 16'h0000;
    end else if (reg_wr && reg_addr == drn_pkg::ADDR_CTRL) begin
      ctl_q <= reg_wdata[21:0];
    end else if (reg_wr && reg_addr == drn_pkg::ADDR_PERI) begin
      per_q <= reg_wdata[15:0];
    end
  end
  assign rep = ctl_q[1] & ~ctl_q[2] & ~ctl_q[6];
  assign wg = bus_wr & bus_grant;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  peri_addr_a: assert property (
    rep && (ctl_q[3] ? bus_rd : bus_wr) |-> bus_addr == {drn_pkg::PERI_HIGH, per_q})
    else $error("peripheral side address wrong");
  quiet_irq_a: assert property (rep |-> !end_irq)
    else $error("end interrupt raised in repeat mode");
  word_mirror_a: assert property ((bus_rd || bus_wr) |-> bus_word == ctl_q[4])
    else $error("access size differs from size bit");
  hold_read_a: assert property (
    bus_rd && !bus_grant |=> bus_rd && $stable(bus_addr))
    else $error("read cycle dropped before grant");
  move_order_a: assert property (bus_rd && bus_grant |=> bus_wr && !bus_rd)
    else $error("write does not follow accepted read");
  data_carry_a: assert property (
    bus_rd && bus_grant |=> bus_wdata == $past(bus_rdata))
    else $error("written data differs from data read");
  steal_release_a: assert property (
    ctl_q[6] && ctl_q[8] && !ctl_q[9] && wg |=> !bus_req)
    else $error("bus kept after cycle steal move");
  irq_cause_a: assert property (
    $rose(end_irq) |-> ctl_q[2] && ($past(wg) || $past(wg, 2)))
    else $error("end interrupt without final move");
endmodule
bind drn_dma drn_dma_chk u_chk (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .bus_grant,
  .bus_req, .bus_addr, .bus_rd, .bus_wr, .bus_word, .bus_wdata, .bus_rdata, .end_irq);
`default_nettype wire

// *** drn_bus_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module drn_bus_model (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [3:0]  stall,      // Grant odds one in stall+1 each cycle; zero grants at once.
  input wire logic        bus_rd,
  input wire logic        bus_wr,
  input wire logic [23:0] bus_addr,
  output logic            bus_grant,
  output logic [15:0]     bus_rdata
);
  logic        go;    // The bus accepts a cycle at the coming edge.
  logic [15:0] junk;  // Changing value shown when no read is answered.
  // Draw the wait state and churn the idle data every cycle.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      go   <= 1'b1;
      junk <= 16'h0000;
    end else begin
      go   <= (stall == 4'h0) || ($urandom_range({28'h0, stall}) == 0);
      junk <= junk + 16'h1357;
    end
  end
  // Each memory word is a fixed scramble of its address.
  assign bus_grant = (bus_rd | bus_wr) & go;
  assign bus_rdata = (bus_rd & go) ? (bus_addr[15:0] ^ 16'h3C5A) : junk;
endmodule
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        clk = 1'b0;        // System clock, 100 ns period.
  logic        rst_b = 1'b0;      // Reset, active low.
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [5:0]  trig_in = 6'h00;   // Internal activation pulses.
  logic        ext_req_b = 1'b1;  // External request, active low.
  logic [3:0]  stall = 4'h0;      // Far side grant odds, one in stall+1.
  logic        bus_grant, bus_req, bus_rd, bus_wr, bus_word, end_irq;
  logic [23:0] bus_addr;
  logic [15:0] bus_wdata, bus_rdata;
  logic [23:0] ra_q[$];           // Accepted read addresses.
  logic [23:0] wa_q[$];           // Accepted write addresses.
  logic [15:0] wd_q[$];           // Data of accepted writes.
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          n_w = 0;           // Moves finished in this run.
  int          gap = 0;           // Cycles without bus request inside a run.
  int          run_n = 0;         // Moves expected in this run.

  initial forever #50 clk = ~clk;

  drn_dma DUT (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .trig_in,
    .ext_req_b, .bus_grant, .bus_req, .bus_addr, .bus_rd, .bus_wr, .bus_word, .bus_wdata,
    .bus_rdata, .end_irq);
  drn_bus_model u_far (.clk, .rst_b, .stall, .bus_rd, .bus_wr, .bus_addr, .bus_grant,
    .bus_rdata);

  // Log every accepted bus cycle and count idle request cycles inside a run.
  always @(posedge clk) begin
    if (bus_grant && bus_rd) ra_q.push_back(bus_addr);
    if (bus_grant && bus_wr) begin
      wa_q.push_back(bus_addr);
      wd_q.push_back(bus_wdata);
      n_w++;
    end
    if (!bus_req && n_w > 0 && n_w < run_n) gap++;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read a register and compare it in the one cycle its data stands.
  task automatic rc(input logic [3:0] a, input logic [31:0] e, input string nm);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(nm, e, reg_rdata);
  endtask

  // Pulse one trigger for a cycle; index 6 pulses the external request.
  task automatic fire(input int b);
    @(posedge clk);
    if (b < 6) trig_in <= 6'(1 << b);
    else ext_req_b <= 1'b0;
    @(posedge clk);
    trig_in   <= 6'h00;
    ext_req_b <= 1'b1;
  endtask

  task automatic wait_w(input int n);
    for (int i = 0; i < 500 && n_w < n; i++) @(posedge clk);
    #1;
    if (n_w < n) begin
      chk("move count", n, n_w);
      end_sim();
    end
  endtask

  task automatic start(input int n);
    n_w   = 0;
    gap   = 0;
    run_n = n;
    ra_q.delete();
    wa_q.delete();
    wd_q.delete();
    stall <= 4'($urandom_range(3));
  endtask

  function automatic logic [23:0] stp(input logic on, input logic dec, input logic sz);
    return on ? (dec ? -(24'h1 << sz) : (24'h1 << sz)) : 24'h0;
  endfunction

  function automatic logic [31:0] rw_exp(input int a, input logic [31:0] d);
    case (a)
      9: return d & 32'h003F3FFE;
      1, 4, 5: return d & 32'h00FFFFFF;
      2, 3, 6: return d & 32'h0000FFFF;
      default: return 32'h0;
    endcase
  endfunction

  initial begin
    logic [23:0] base, sa, da, ds, dd, ma;
    logic [15:0] pl;
    logic [31:0] ctl, v;
    int          nq;
    void'($urandom(32'h6C8F));
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    for (int a = 0; a < 8; a++) rc(4'(a), 32'h0, "reset value");
    // Write and read back indices 0 to 7, the read-only one included, and unmapped index F.
    for (int a = 1; a < 10; a++) begin
      v = rw_exp(9, $urandom) | (a == 9 ? 32'h0 : $urandom);
      wr(a == 8 ? 4'hF : (a == 9 ? 4'h0 : 4'(a)), v);
      rc(a == 8 ? 4'hF : (a == 9 ? 4'h0 : 4'(a)), rw_exp(a, v), "read back");
    end
    // Repeat mode: each trigger source, size, step sign and direction.
    for (int c = 0; c < 6; c++) begin
      nq = (c == 5) ? 256 : c + 1;
      base = 24'($urandom) & 24'hFFFFFE;
      pl = 16'($urandom);
      ma = stp(1'b1, c[1], c[0]);
      ctl = 32'h3 | (32'(c[2]) << 3) | (32'(c[0]) << 4) | (32'(c[1]) << 5) | (32'h1 << (16 + c));
      wr(drn_pkg::ADDR_MEM, {8'h0, base});
      wr(drn_pkg::ADDR_PERI, {16'h0, pl});
      wr(drn_pkg::ADDR_RCOUNT, {16'h0, 8'(nq), 8'(nq)});
      wr(drn_pkg::ADDR_CTRL, ctl);
      start(0);
      fire((c + 1) % 6);
      fire(6);
      repeat (10) @(posedge clk);
      chk("foreign trigger", 0, n_w);
      for (int k = 0; k <= nq + 2; k++) begin
        if (k == nq + 2) begin
          wr(drn_pkg::ADDR_CTRL, ctl & ~32'h1);
          fire(c);
          repeat (10) @(posedge clk);
          chk("stopped", k, n_w);
          wr(drn_pkg::ADDR_CTRL, ctl);
        end
        fire(c);
        wait_w(k + 1);
        sa = 24'(base + ma * (k % nq));
        chk("memory side", sa, c[2] ? wa_q[k] : ra_q[k]);
        chk("peripheral side", {drn_pkg::PERI_HIGH, pl},
            c[2] ? ra_q[k] : wa_q[k]);
        if (c[0]) chk("word data", (c[2] ? pl : sa[15:0]) ^ 16'h3C5A, wd_q[k]);
      end
      rc(drn_pkg::ADDR_RCOUNT, {16'h0, 8'(nq), 8'(nq - (nq + 3) % nq)}, "count");
      rc(drn_pkg::ADDR_MEM, {8'h0, 24'(base + ma * ((nq + 3) % nq))}, "restore");
      chk("end irq", 0, end_irq);
    end
    // Normal mode: burst, cycle steal and external requests, every step mode.
    for (int c = 0; c < 4; c++) begin
      nq = 2 + c;
      sa = 24'($urandom);
      da = 24'($urandom);
      ds = stp(c[0], c[1], c[0]);
      dd = stp(~c[0], ~c[1], c[0]);
      ctl = 32'h41 | (32'(c != 3) << 2) | (32'(c[0]) << 4) | (32'(c < 2) << 8) |
            (32'(c == 0) << 9) | (32'(c) << 10) | (32'(3 - c) << 12);
      wr(drn_pkg::ADDR_SRC_A, {8'h0, sa});
      wr(drn_pkg::ADDR_DST_B, {8'h0, da});
      wr(drn_pkg::ADDR_FCOUNT, 32'(nq));
      start(nq);
      wr(drn_pkg::ADDR_CTRL, ctl);
      for (int k = 0; k < nq; k++) begin
        if (c >= 2) fire(6);
        wait_w(k + 1);
        chk("source", 24'(sa + ds * k), ra_q[k]);
        chk("destination", 24'(da + dd * k), wa_q[k]);
        if (c[0]) chk("word data", 16'(sa + ds * k) ^ 16'h3C5A, wd_q[k]);
      end
      repeat (10) @(posedge clk);
      chk("moves", nq, n_w);
      if (c == 0) chk("burst gaps", 0, gap);
      if (c == 1) chk("steal gaps", 1, gap >= nq - 1);
      rc(drn_pkg::ADDR_CTRL, ctl & ~32'h1, "auto stop");
      rc(drn_pkg::ADDR_FCOUNT, 32'h0, "count end");
      rc(drn_pkg::ADDR_SRC_A, {8'h0, 24'(sa + ds * nq)}, "final source");
      chk("end irq", c != 3, end_irq);
    end
    // Refused modes, then a zero count that must not end after a few moves.
    start(0);
    wr(drn_pkg::ADDR_FCOUNT, 32'h0);
    wr(drn_pkg::ADDR_CTRL, 32'h003F0007);
    fire(0);
    wr(drn_pkg::ADDR_CTRL, 32'h000001C1);
    repeat (10) @(posedge clk);
    chk("refused mode", 0, n_w);
    wr(drn_pkg::ADDR_CTRL, 32'h00000041);
    for (int k = 0; k < 3; k++) begin
      fire(6);
      wait_w(k + 1);
    end
    rc(drn_pkg::ADDR_FCOUNT, 32'h0000FFFD, "zero count");
    rc(drn_pkg::ADDR_CTRL, 32'h00000041, "still enabled");
    end_sim();
  end
endmodule
`default_nettype wire
